// *** bench/dpc_clock_ctrl_asserts.sv ***
// Checker for the clock controller: bus handshake and strobe relations.
// Assumes it is bound to dpc_clock_ctrl and sees only its ports.
`default_nettype none
module dpc_clock_ctrl_asserts
	import dpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ref_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic domain_clk_first_o,
	input wire logic domain_clk_periph_o,
	input wire logic domain_clk_video_sub_o,
	input wire logic ref_passthru_clk_o,
	input wire logic clock_out_pin_a_o,
	input wire logic clock_out_pin_b_o,
	input wire logic clock_out_pin_c_o,
	input wire logic [DIV_W-1:0] main_pre_pll_divider_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cb_ff, cc_ff;
	logic sb_ff, sc_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Reference strobes since the last pin b and pin c strobe
	always_ff @(posedge clk_i) begin
		cb_ff <= (rst_i || clock_out_pin_b_o) ? 4'h0 : cb_ff + 4'(clock_out_pin_a_o);
		cc_ff <= (rst_i || clock_out_pin_c_o) ? 4'h0 : cc_ff + 4'(clock_out_pin_a_o);
	end
	// Pin strobed at least once since reset
	always_ff @(posedge clk_i) begin
		sb_ff <= !rst_i && (sb_ff || clock_out_pin_b_o);
		sc_ff <= !rst_i && (sc_ff || clock_out_pin_c_o);
	end
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_pin_a_mirror: assert property (clock_out_pin_a_o == ref_passthru_clk_o)
		else $error("pin a differs from pass-through");
	a_ref_passthru: assert property ($rose(ref_clk_i) |-> ##[1:2] ref_passthru_clk_o)
		else $error("reference edge not passed through");
	a_pin_b_third: assert property (clock_out_pin_a_o && sb_ff |->
		clock_out_pin_b_o == (cb_ff == 4'h2)) else $error("pin b not every third edge");
	a_pin_c_eighth: assert property (clock_out_pin_a_o && sc_ff |->
		clock_out_pin_c_o == (cc_ff == 4'h7)) else $error("pin c not every eighth edge");
	a_periph_aligned: assert property (domain_clk_periph_o |-> domain_clk_first_o)
		else $error("peripheral clock off first edge");
	a_vsub_aligned: assert property (domain_clk_video_sub_o |-> domain_clk_first_o)
		else $error("video clock off first edge");
	a_first_no_runt: assert property (domain_clk_first_o |=> !domain_clk_first_o)
		else $error("runt pulse on first domain");
	a_pre_pll_divider_fixed: assert property (main_pre_pll_divider_o == MAIN_PRE_PLL_DIV)
		else $error("main pre-divider not fixed");
	c_ack: cover property (wb_ack_o);
	c_pin_c: cover property (clock_out_pin_c_o);
	c_vsub: cover property (domain_clk_video_sub_o && domain_clk_periph_o);
endmodule

bind dpc_clock_ctrl dpc_clock_ctrl_asserts dpc_clock_ctrl_asserts_i (.*);
`default_nettype wire

// *** bench/dpc_consumer.sv ***
// Clock consumer model: tallies strobes of every domain and pin clock.
// Assumes one-cycle strobes in the clk_i domain.
`default_nettype none
module dpc_consumer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic [8:0] strobe_i,
	output logic [8:0][15:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each strobe counts as one consumer clock edge
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 9; i++) begin
			cnt_o[i] <= (rst_i || clr_i) ? 16'h0000 : cnt_o[i] + 16'(strobe_i[i]);
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_dpc_clock_ctrl.sv ***
// Testbench for the clock controller: registers, bypass and PLL rates.
// Assumes a reference at a quarter of clk_i, made by the bench.
`default_nettype none
module tb_dpc_clock_ctrl
	import dpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic clr = 1'b0, ref_clk_i, wb_ack_o, main_pll_pwrdn_o, mem_pll_pwrdn_o;
	logic [1:0] rdiv_ff = 2'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic domain_clk_first_o, domain_clk_periph_o, domain_clk_video_enc_o;
	logic domain_clk_video_sub_o, ref_passthru_clk_o, mem_domain_clk_first_o;
	logic clock_out_pin_a_o, clock_out_pin_b_o, clock_out_pin_c_o;
	logic [DIV_W-1:0] main_pre_pll_divider_o, mem_pre_pll_divider_o;
	logic [MULT_W-1:0] main_pll_multiplier_o, mem_pll_multiplier_o;
	logic [8:0][15:0] cnt;
	int errors = 0, checks = 0, ticks = 0;
	assign ref_clk_i = rdiv_ff[1];
	dpc_clock_ctrl dpc_clock_ctrl_i (.*);
	dpc_consumer dpc_consumer_i (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .cnt_o(cnt),
		.strobe_i({mem_domain_clk_first_o, clock_out_pin_c_o, clock_out_pin_b_o,
		clock_out_pin_a_o, ref_passthru_clk_o, domain_clk_video_sub_o,
		domain_clk_video_enc_o, domain_clk_periph_o, domain_clk_first_o}));
	// Clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Reference divider and hang limit
	always @(posedge clk_i) begin
		rdiv_ff <= rdiv_ff + 2'h1;
		ticks++;
		if (ticks == 20000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rate(input int i, input int src, input int dv);
		int e;
		e = src / dv;
		checks++;
		if ($isunknown(cnt[i]) || cnt[i] + 1 < e || cnt[i] > e + 1) begin
			errors++;
			$display("BAD strobe %0d exp %0d got %0d", i, e, cnt[i]);
		end
	endtask
	task automatic win(input int n);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic go(input logic [31:0] m);
		wb(1'b1, CMD_OFS, m, 4'hF);
		do wb(1'b0, STATUS_OFS, 32'h0000_0000, 4'hF); while (rd[1:0] !== 2'b00);
	endtask
	task automatic t_regs();
		logic [7:0] a [9] = '{MAIN_CTRL_OFS, MAIN_MULT_OFS, MAIN_DIV3_OFS, MEM_CTRL_OFS,
			MEM_PRE_PLL_DIVIDER_OFS, MEM_MULT_OFS, CMD_OFS, STATUS_OFS, 8'h20};
		logic [9:0] e [9] = '{10'h000, 10'h060, 10'h00A, 10'h000, 10'h00C, 10'h072,
			10'h000, 10'h000, 10'h000};
		wb(1'b1, MAIN_DIV3_OFS, 32'h0000_0003, 4'hE);
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, a[i], 32'h0000_0000, 4'hF);
			cmp("register", 32'(e[i]), rd);
		end
		cmp("pre divider", 32'h0000_0008, 32'(main_pre_pll_divider_o));
		$display("t_regs done");
	endtask
	task automatic t_bypass();
		win(320);
		rate(0, 80, 2);
		rate(1, 80, 4);
		rate(2, 80, 10);
		rate(3, 80, 4);
		rate(5, 80, 1);
		rate(6, 80, 3);
		rate(7, 80, 8);
		rate(8, 80, 1);
		$display("t_bypass done");
	endtask
	task automatic t_pll();
		wb(1'b1, MAIN_MULT_OFS, 32'h0000_00B4, 4'hF);
		wb(1'b1, MAIN_DIV3_OFS, 32'h0000_0005, 4'hF);
		wb(1'b1, MAIN_CTRL_OFS, 32'h0000_0001, 4'hF);
		wb(1'b1, MEM_CTRL_OFS, 32'h0000_0001, 4'hF);
		wb(1'b1, MEM_PRE_PLL_DIVIDER_OFS, 32'h0000_001B, 4'hF);
		wb(1'b1, MEM_MULT_OFS, 32'h0000_0096, 4'hF);
		cmp("mult held", 32'h0000_0060, 32'(main_pll_multiplier_o));
		go(32'h0000_0003);
		cmp("pll active", 32'h0000_000C, rd);
		cmp("main mult", 32'h0000_00B4, 32'(main_pll_multiplier_o));
		cmp("mem pre_pll_divider", 32'h0000_001B, 32'(mem_pre_pll_divider_o));
		cmp("mem mult", 32'h0000_0096, 32'(mem_pll_multiplier_o));
		win(200);
		rate(0, 200, 2);
		rate(1, 200, 4);
		rate(2, 200, 5);
		rate(3, 200, 4);
		rate(8, 200, 1);
		rate(6, 50, 3);
		go(32'h0000_0001);
		cmp("reapply", 32'h0000_000C, rd);
		wb(1'b1, MAIN_CTRL_OFS, 32'h0000_000D, 4'hF);
		go(32'h0000_0001);
		win(200);
		rate(0, 100, 2);
		rate(1, 100, 4);
		rate(3, 100, 2);
		$display("t_pll done");
	endtask
	task automatic t_pwr();
		wb(1'b1, MAIN_CTRL_OFS, 32'h0000_0002, 4'hF);
		wb(1'b1, MEM_CTRL_OFS, 32'h0000_0002, 4'hF);
		go(32'h0000_0003);
		cmp("back to bypass", 32'h0000_0000, rd);
		cmp("main pwrdn", 32'h0000_0001, 32'(main_pll_pwrdn_o));
		cmp("mem pwrdn", 32'h0000_0001, 32'(mem_pll_pwrdn_o));
		wb(1'b1, MAIN_CTRL_OFS, 32'h0000_0003, 4'hF);
		go(32'h0000_0001);
		cmp("pwrdn in pll", 32'h0000_0000, 32'(main_pll_pwrdn_o));
		$display("t_pwr done");
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_bypass();
		t_pll();
		t_pwr();
		complete_run();
	end
endmodule
`default_nettype wire

// *** core/dpc_clock_ctrl.sv ***
// Dual PLL clock controller: main and memory controllers behind one Wishbone slave.
// Assumes clk_i stands for the locked PLL output and ref_clk_i is a synchronous
// copy of the shared reference; the analog PLLs take the exported settings.
// Domain clocks appear as one-cycle strobes, one per output period.
`default_nettype none

// Notes on behaviour
// - Main setting changes wait for a common divider edge; memory ones apply as soon as pending
// - Main controller configured through its registers
// - Main pre-divider fixed /8, multiplier programmable
// - Main drives exactly four domain clocks
// - First domain is PLL /2 to processor
// - Second domain is PLL /4 to peripherals
// - Third domain programmable /n for video encoder
// - Fourth domain selectable /4 or /2
// - Main bypass clock is reference /3, pin b
// - Reference passes through undivided to pin a
// - Memory controller shares the main reference input
// - Memory pre-divider and multiplier are programmable
// - Memory post-divider fixed at /1
// - Memory first domain is PLL /1 to PHY
// - Memory bypass clock is reference /8, pin c
// - Main post-divider selectable /2 or /1
module dpc_clock_ctrl
	import dpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ref_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic domain_clk_first_o,
	output logic domain_clk_periph_o,
	output logic domain_clk_video_enc_o,
	output logic domain_clk_video_sub_o,
	output logic ref_passthru_clk_o,
	output logic clock_out_pin_a_o,
	output logic clock_out_pin_b_o,
	output logic clock_out_pin_c_o,
	output logic mem_domain_clk_first_o,
	output logic [DIV_W-1:0] main_pre_pll_divider_o,
	output logic [MULT_W-1:0] main_pll_multiplier_o,
	output logic main_pll_pwrdn_o,
	output logic [DIV_W-1:0] mem_pre_pll_divider_o,
	output logic [MULT_W-1:0] mem_pll_multiplier_o,
	output logic mem_pll_pwrdn_o
);

	// Next count of a modulo-n divider; zero or one ratio means every tick
	function automatic logic [DIV_W-1:0] div_next(input logic [DIV_W-1:0] cnt,
		input logic [DIV_W-1:0] n);
		div_next = (n <= 5'h01 || cnt >= n - 5'h01) ? 5'h00 : cnt + 5'h01;
	endfunction

	// Shadow (software) and active settings
	logic [3:0] main_ctrl_ff;
	logic [3:0] main_act_ff;
	logic [MULT_W-1:0] main_mult_ff;
	logic [MULT_W-1:0] main_mult_act_ff;
	logic [DIV_W-1:0] main_div3_ff;
	logic [DIV_W-1:0] main_div3_act_ff;
	logic [1:0] mem_ctrl_ff;
	logic [1:0] mem_act_ff;
	logic [DIV_W-1:0] mem_pre_pll_divider_ff;
	logic [DIV_W-1:0] mem_pre_pll_divider_act_ff;
	logic [MULT_W-1:0] mem_mult_ff;
	logic [MULT_W-1:0] mem_mult_act_ff;
	logic main_pend_ff;
	logic mem_pend_ff;

	// Divider state
	logic ref_q_ff;
	logic post_ff;
	logic [DIV_W-1:0] cnt1_ff;
	logic [DIV_W-1:0] cnt2_ff;
	logic [DIV_W-1:0] cnt3_ff;
	logic [DIV_W-1:0] cnt4_ff;
	logic [DIV_W-1:0] bp_main_cnt_ff;
	logic [DIV_W-1:0] bp_mem_cnt_ff;

	logic wr_stb;
	logic ref_rise;
	logic main_tick;
	logic mem_tick;
	logic [DIV_W-1:0] div4_ratio;
	logic main_aligned;
	logic main_apply;
	logic mem_apply;

	// Bus write strobe, taken once per access at the ack edge
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	// Reference edge shared by both controllers
	assign ref_rise = ref_clk_i && !ref_q_ff;

	// Main source tick: reference in bypass, PLL output after post-divider otherwise
	assign main_tick = main_act_ff[CTRL_PLL_EN_BIT] ?
		(!main_act_ff[CTRL_POST2_BIT] || post_ff) : ref_rise;
	// Memory source tick: post-divider is always /1
	assign mem_tick = mem_act_ff[CTRL_PLL_EN_BIT] ? 1'b1 : ref_rise;

	assign div4_ratio = main_act_ff[CTRL_DIV4_HALF_BIT] ?
		MAIN_VSUB_DIV_FAST : MAIN_VSUB_DIV_SLOW;

	// All main dividers at a common edge
	assign main_aligned = (cnt1_ff == 5'h00) && (cnt2_ff == 5'h00) &&
		(cnt3_ff == 5'h00) && (cnt4_ff == 5'h00) && !post_ff;
	assign main_apply = main_pend_ff && main_aligned;
	assign mem_apply = mem_pend_ff;

	// Wishbone ack, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Read data, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_dat_o <= 32'h0000_0000;
			unique case (wb_adr_i)
				MAIN_CTRL_OFS: wb_dat_o[3:0] <= main_ctrl_ff;
				MAIN_MULT_OFS: wb_dat_o[MULT_W-1:0] <= main_mult_ff;
				MAIN_DIV3_OFS: wb_dat_o[DIV_W-1:0] <= main_div3_ff;
				MEM_CTRL_OFS: wb_dat_o[1:0] <= mem_ctrl_ff;
				MEM_PRE_PLL_DIVIDER_OFS: wb_dat_o[DIV_W-1:0] <= mem_pre_pll_divider_ff;
				MEM_MULT_OFS: wb_dat_o[MULT_W-1:0] <= mem_mult_ff;
				STATUS_OFS: begin
					wb_dat_o[STAT_MAIN_PEND_BIT] <= main_pend_ff;
					wb_dat_o[STAT_MEM_PEND_BIT] <= mem_pend_ff;
					wb_dat_o[STAT_MAIN_PLL_BIT] <= main_act_ff[CTRL_PLL_EN_BIT];
					wb_dat_o[STAT_MEM_PLL_BIT] <= mem_act_ff[CTRL_PLL_EN_BIT];
				end
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Shadow registers written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_ctrl_ff <= CTRL_RST;
			main_mult_ff <= MAIN_MULT_RST;
			main_div3_ff <= MAIN_DIV3_RST;
			mem_ctrl_ff <= CTRL_RST[1:0];
			mem_pre_pll_divider_ff <= MEM_PRE_PLL_DIVIDER_RST;
			mem_mult_ff <= MEM_MULT_RST;
		end else if (wr_stb) begin
			unique case (wb_adr_i)
				MAIN_CTRL_OFS: main_ctrl_ff <= wb_dat_i[3:0];
				MAIN_MULT_OFS: main_mult_ff <= wb_dat_i[MULT_W-1:0];
				MAIN_DIV3_OFS: main_div3_ff <= wb_dat_i[DIV_W-1:0];
				MEM_CTRL_OFS: mem_ctrl_ff <= wb_dat_i[1:0];
				MEM_PRE_PLL_DIVIDER_OFS: mem_pre_pll_divider_ff <= wb_dat_i[DIV_W-1:0];
				MEM_MULT_OFS: mem_mult_ff <= wb_dat_i[MULT_W-1:0];
				default: ;
			endcase
		end
	end

	// Pending flags: set by a go command, cleared when applied; set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_pend_ff <= 1'b0;
			mem_pend_ff <= 1'b0;
		end else begin
			if (wr_stb && wb_adr_i == CMD_OFS && wb_dat_i[CMD_GO_MAIN_BIT]) begin
				main_pend_ff <= 1'b1;
			end else if (main_apply) begin
				main_pend_ff <= 1'b0;
			end
			if (wr_stb && wb_adr_i == CMD_OFS && wb_dat_i[CMD_GO_MEM_BIT]) begin
				mem_pend_ff <= 1'b1;
			end else if (mem_apply) begin
				mem_pend_ff <= 1'b0;
			end
		end
	end

	// Main active settings change only at a common divider edge, memory ones as soon as pending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_act_ff <= CTRL_RST;
			main_mult_act_ff <= MAIN_MULT_RST;
			main_div3_act_ff <= MAIN_DIV3_RST;
			mem_act_ff <= CTRL_RST[1:0];
			mem_pre_pll_divider_act_ff <= MEM_PRE_PLL_DIVIDER_RST;
			mem_mult_act_ff <= MEM_MULT_RST;
		end else begin
			if (main_apply) begin
				main_act_ff <= main_ctrl_ff;
				main_mult_act_ff <= main_mult_ff;
				main_div3_act_ff <= main_div3_ff;
			end
			if (mem_apply) begin
				mem_act_ff <= mem_ctrl_ff;
				mem_pre_pll_divider_act_ff <= mem_pre_pll_divider_ff;
				mem_mult_act_ff <= mem_mult_ff;
			end
		end
	end

	// Settings exported to the analog PLLs; power-down only honoured in bypass
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_pre_pll_divider_o <= MAIN_PRE_PLL_DIV;
			main_pll_multiplier_o <= MAIN_MULT_RST;
			main_pll_pwrdn_o <= 1'b0;
			mem_pre_pll_divider_o <= MEM_PRE_PLL_DIVIDER_RST;
			mem_pll_multiplier_o <= MEM_MULT_RST;
			mem_pll_pwrdn_o <= 1'b0;
		end else begin
			main_pre_pll_divider_o <= MAIN_PRE_PLL_DIV;
			main_pll_multiplier_o <= main_mult_act_ff;
			main_pll_pwrdn_o <= main_act_ff[CTRL_PWRDN_BIT] &&
				!main_act_ff[CTRL_PLL_EN_BIT];
			mem_pre_pll_divider_o <= mem_pre_pll_divider_act_ff;
			mem_pll_multiplier_o <= mem_mult_act_ff;
			mem_pll_pwrdn_o <= mem_act_ff[CTRL_PWRDN_BIT] &&
				!mem_act_ff[CTRL_PLL_EN_BIT];
		end
	end

	// Reference sampler and main post-divider phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_q_ff <= ref_clk_i; // Track the pin so release shows no false edge
			post_ff <= 1'b0;
		end else begin
			ref_q_ff <= ref_clk_i;
			if (main_apply || !main_act_ff[CTRL_PLL_EN_BIT] ||
				!main_act_ff[CTRL_POST2_BIT]) begin
				post_ff <= 1'b0;
			end else begin
				post_ff <= !post_ff;
			end
		end
	end

	// Main domain dividers share one tick; apply lands only where all read zero,
	// so they keep counting through it and no period is cut short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt1_ff <= 5'h00;
			cnt2_ff <= 5'h00;
			cnt3_ff <= 5'h00;
			cnt4_ff <= 5'h00;
		end else if (main_tick) begin
			cnt1_ff <= div_next(cnt1_ff, MAIN_FIRST_DIV);
			cnt2_ff <= div_next(cnt2_ff, MAIN_PERIPH_DIV);
			cnt3_ff <= div_next(cnt3_ff, main_div3_act_ff);
			cnt4_ff <= div_next(cnt4_ff, div4_ratio);
		end
	end

	// Bypass dividers run from the reference regardless of mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bp_main_cnt_ff <= 5'h00;
			bp_mem_cnt_ff <= 5'h00;
		end else if (ref_rise) begin
			bp_main_cnt_ff <= div_next(bp_main_cnt_ff, MAIN_BYPASS_DIV);
			bp_mem_cnt_ff <= div_next(bp_mem_cnt_ff, MEM_BYPASS_DIV);
		end
	end

	// Main domain strobes, one per divided period; only four domains exist
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			domain_clk_first_o <= 1'b0;
			domain_clk_periph_o <= 1'b0;
			domain_clk_video_enc_o <= 1'b0;
			domain_clk_video_sub_o <= 1'b0;
		end else begin
			domain_clk_first_o <= main_tick && cnt1_ff == 5'h00;
			domain_clk_periph_o <= main_tick && cnt2_ff == 5'h00;
			domain_clk_video_enc_o <= main_tick && cnt3_ff == 5'h00;
			domain_clk_video_sub_o <= main_tick && cnt4_ff == 5'h00;
		end
	end

	// Reference pass-through, bypass clocks and memory domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_passthru_clk_o <= 1'b0;
			clock_out_pin_a_o <= 1'b0;
			clock_out_pin_b_o <= 1'b0;
			clock_out_pin_c_o <= 1'b0;
			mem_domain_clk_first_o <= 1'b0;
		end else begin
			ref_passthru_clk_o <= ref_rise;
			clock_out_pin_a_o <= ref_rise;
			clock_out_pin_b_o <= ref_rise && bp_main_cnt_ff == 5'h00;
			clock_out_pin_c_o <= ref_rise && bp_mem_cnt_ff == 5'h00;
			mem_domain_clk_first_o <= mem_tick;
		end
	end

endmodule

`default_nettype wire

// *** core/dpc_pkg.sv ***
// Shared constants for the dual PLL clock controller.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none

package dpc_pkg;

	// Register byte offsets
	localparam logic [7:0] MAIN_CTRL_OFS = 8'h00;
	localparam logic [7:0] MAIN_MULT_OFS = 8'h04;
	localparam logic [7:0] MAIN_DIV3_OFS = 8'h08;
	localparam logic [7:0] MEM_CTRL_OFS = 8'h0C;
	localparam logic [7:0] MEM_PRE_PLL_DIVIDER_OFS = 8'h10;
	localparam logic [7:0] MEM_MULT_OFS = 8'h14;
	localparam logic [7:0] CMD_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1C;

	// Control field positions
	localparam int CTRL_PLL_EN_BIT = 0;
	localparam int CTRL_PWRDN_BIT = 1;
	localparam int CTRL_POST2_BIT = 2;
	localparam int CTRL_DIV4_HALF_BIT = 3;
	localparam int CMD_GO_MAIN_BIT = 0;
	localparam int CMD_GO_MEM_BIT = 1;
	localparam int STAT_MAIN_PEND_BIT = 0;
	localparam int STAT_MEM_PEND_BIT = 1;
	localparam int STAT_MAIN_PLL_BIT = 2;
	localparam int STAT_MEM_PLL_BIT = 3;

	// Field widths
	localparam int MULT_W = 10;
	localparam int DIV_W = 5;

	// Fixed divider ratios
	localparam logic [DIV_W-1:0] MAIN_PRE_PLL_DIV = 5'h08;
	localparam logic [DIV_W-1:0] MAIN_FIRST_DIV = 5'h02;
	localparam logic [DIV_W-1:0] MAIN_PERIPH_DIV = 5'h04;
	localparam logic [DIV_W-1:0] MAIN_VSUB_DIV_SLOW = 5'h04;
	localparam logic [DIV_W-1:0] MAIN_VSUB_DIV_FAST = 5'h02;
	localparam logic [DIV_W-1:0] MAIN_BYPASS_DIV = 5'h03;
	localparam logic [DIV_W-1:0] MEM_BYPASS_DIV = 5'h08;

	// Reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [MULT_W-1:0] MAIN_MULT_RST = 10'h060;
	localparam logic [DIV_W-1:0] MAIN_DIV3_RST = 5'h0A;
	localparam logic [DIV_W-1:0] MEM_PRE_PLL_DIVIDER_RST = 5'h0C;
	localparam logic [MULT_W-1:0] MEM_MULT_RST = 10'h072;

endpackage

`default_nettype wire
